// ### src/crlt_unit.v
// crlt_unit.v: condition-register bit logic, field copy, service call and trap unit
// assumes decode presents one command per cycle with op_valid and takes exceptions as pulses
//
// Contract
// RULE_01: combine two condition bits by one of eight boolean ops, write any bit
// RULE_02: bit-op operands each index a single condition-register bit
// RULE_03: condition register is eight four-bit fields for field copy
// RULE_04: field copy moves source field to destination, others unchanged
// RULE_05: service call allowed in user mode, enters privileged mode
// RULE_06: service call always raises system-call exception at vector 0x0c00
// RULE_07: register trap compares two registers, program exception at 0x0700
// RULE_08: immediate trap compares register with sign-extended immediate
// RULE_09: no enabled condition true means no exception, continue next instruction
// RULE_10: enabled conditions are ORed; all five set always traps
// RULE_11: mask bit 0 enables signed less-than trap
// RULE_12: mask bit 1 enables signed greater-than trap
// RULE_13: mask bit 2 enables equality trap
// RULE_14: mask bit 3 enables unsigned less-than trap
// RULE_15: mask bit 4 enables unsigned greater-than trap
// RULE_16: satisfied trap also raises debug exception when trap debug enabled
// RULE_17: immediate is 16 bits sign-extended; registers compared at 32 bits
// RULE_18: mask and condition bits numbered from the most significant end
`timescale 1ns/10ps
`include "crlt_defs.vh"

module crlt_unit (
  input wire clock,
  input wire resetn,
  input wire op_valid,
  input wire [2:0] op_cmd,
  input wire [2:0] bit_op,
  input wire [4:0] source_bit_a,
  input wire [4:0] source_bit_b,
  input wire [4:0] dest_bit,
  input wire [2:0] source_field,
  input wire [2:0] dest_field,
  input wire [31:0] source_gpr_a,
  input wire [31:0] source_gpr_b,
  input wire [15:0] signed_immediate,
  input wire [4:0] trap_condition_mask,
  input wire user_mode,
  input wire trap_debug_enable,
  input wire cr_load,
  input wire [31:0] cr_load_data,
  output wire [31:0] condition_register,
  output reg svc_exception,
  output reg prog_exception,
  output reg debug_exception,
  output reg [15:0] exception_vector,
  output reg enter_privileged,
  output reg op_done
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // big-endian bit index: bit 0 is the msb
  function [4:0] be_pos;
    input [4:0] idx;
    begin
      be_pos = 5'h1f - idx;
    end
  endfunction

  function bool_op;
    input [2:0] code;
    input a;
    input b;
    begin
      case (code)
        `CRLT_OP_AND: bool_op = a & b;
        `CRLT_OP_ANDC: bool_op = a & ~b;
        `CRLT_OP_XNOR: bool_op = ~(a ^ b);
        `CRLT_OP_NAND: bool_op = ~(a & b);
        `CRLT_OP_NOR: bool_op = ~(a | b);
        `CRLT_OP_OR: bool_op = a | b;
        `CRLT_OP_ORC: bool_op = a | ~b;
        default: bool_op = a ^ b;
      endcase
    end
  endfunction

  // ----------------------------------------
  // condition register
  // ----------------------------------------
  reg [31:0] cr_reg;
  reg [31:0] cr_next;
  wire bit_a;
  wire bit_b;
  wire bit_res;
  wire [3:0] src_nib;
  wire [2:0] src_slot;
  wire [2:0] dst_slot;

  assign condition_register = cr_reg;
  assign bit_a = cr_reg[be_pos(source_bit_a)]; // RULE_02 RULE_18
  assign bit_b = cr_reg[be_pos(source_bit_b)]; // RULE_02
  assign bit_res = bool_op(bit_op, bit_a, bit_b); // RULE_01
  // field 0 sits in bits 31:28
  assign src_slot = 3'h7 - source_field; // RULE_03
  assign dst_slot = 3'h7 - dest_field; // RULE_03

  genvar g;
  wire [3:0] fields [0:7];
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_field
      assign fields[g] = cr_reg[g*4+3:g*4];
    end
  endgenerate
  assign src_nib = fields[src_slot];

  integer k;
  always @* begin
    cr_next = cr_reg;
    if (cr_load) begin
      cr_next = cr_load_data;
    end else if (op_valid) begin
      case (op_cmd)
        `CRLT_CMD_BITOP: begin
          cr_next[be_pos(dest_bit)] = bit_res; // RULE_01 RULE_02
        end
        `CRLT_CMD_FCOPY: begin
          for (k = 0; k < 8; k = k + 1) begin
            if (k[2:0] == dst_slot) begin
              cr_next[k*4 +: 4] = src_nib; // RULE_04
            end
          end
        end
        default: begin
          cr_next = cr_reg;
        end
      endcase
    end
  end

  // ----------------------------------------
  // trap evaluation
  // ----------------------------------------
  wire [31:0] imm_ext;
  wire [31:0] cmp_b;
  wire trap_hit;
  wire is_trap;
  assign imm_ext = {{16{signed_immediate[15]}}, signed_immediate}; // RULE_17
  // register trap uses second gpr, immediate trap the extended immediate
  assign cmp_b = (op_cmd == `CRLT_CMD_TRAPI) ? imm_ext : source_gpr_b; // RULE_07 RULE_08
  assign is_trap = (op_cmd == `CRLT_CMD_TRAPR) | (op_cmd == `CRLT_CMD_TRAPI);

  crlt_trap_cmp u_cmp (
    .operand_a(source_gpr_a),
    .operand_b(cmp_b),
    .trap_condition_mask(trap_condition_mask),
    .trap_hit(trap_hit)
  );

  // ----------------------------------------
  // exception requests, one-cycle pulses
  // ----------------------------------------
  always @(posedge clock) begin
    if (!resetn) begin
      cr_reg <= `CRLT_CR_RESET;
      svc_exception <= 1'b0;
      prog_exception <= 1'b0;
      debug_exception <= 1'b0;
      exception_vector <= 16'h0000;
      enter_privileged <= 1'b0;
      op_done <= 1'b0;
    end else begin
      cr_reg <= cr_next;
      svc_exception <= 1'b0;
      prog_exception <= 1'b0;
      debug_exception <= 1'b0;
      enter_privileged <= 1'b0;
      op_done <= op_valid;
      if (op_valid && op_cmd == `CRLT_CMD_SVC) begin
        // no operands, no condition; legal from user mode too
        svc_exception <= 1'b1; // RULE_06
        exception_vector <= `CRLT_VEC_SVC; // RULE_06
        enter_privileged <= user_mode; // RULE_05
      end else if (op_valid && is_trap && trap_hit) begin
        prog_exception <= 1'b1; // RULE_07 RULE_08
        exception_vector <= `CRLT_VEC_PROG; // RULE_07
        debug_exception <= trap_debug_enable; // RULE_16
      end else if (op_valid) begin
        // trap not met: nothing raised, decode proceeds to next instruction
        exception_vector <= 16'h0000; // RULE_09
      end
    end
  end
endmodule // crlt_unit

// ### pkg/crlt_defs.vh
// crlt_defs.vh: constants for the condition-register logic and trap unit
// assumes inclusion by bare name from any design file of the unit
`ifndef CRLT_DEFS_VH
`define CRLT_DEFS_VH

// ----------------------------------------
// bit operation codes
// ----------------------------------------
`define CRLT_OP_AND  3'h0
`define CRLT_OP_ANDC 3'h1
`define CRLT_OP_XNOR 3'h2
`define CRLT_OP_NAND 3'h3
`define CRLT_OP_NOR  3'h4
`define CRLT_OP_OR   3'h5
`define CRLT_OP_ORC  3'h6
`define CRLT_OP_XOR  3'h7

// ----------------------------------------
// command codes
// ----------------------------------------
`define CRLT_CMD_BITOP 3'h0
`define CRLT_CMD_FCOPY 3'h1
`define CRLT_CMD_SVC   3'h2
`define CRLT_CMD_TRAPR 3'h3
`define CRLT_CMD_TRAPI 3'h4

// ----------------------------------------
// trap mask positions, big-endian field numbering
// ----------------------------------------
`define CRLT_TM_SLT 4
`define CRLT_TM_SGT 3
`define CRLT_TM_EQ  2
`define CRLT_TM_ULT 1
`define CRLT_TM_UGT 0

// ----------------------------------------
// vectors and reset values
// ----------------------------------------
`define CRLT_VEC_SVC  16'h0c00
`define CRLT_VEC_PROG 16'h0700
`define CRLT_CR_RESET 32'h00000000

`endif

// ### src/crlt_trap_cmp.v
// crlt_trap_cmp.v: trap condition evaluator, purely combinational
// assumes operands are stable in the cycle the caller samples the result
`timescale 1ns/10ps
`include "crlt_defs.vh"

module crlt_trap_cmp (
  input wire [31:0] operand_a,
  input wire [31:0] operand_b,
  input wire [4:0] trap_condition_mask,
  output wire trap_hit
);
  wire slt;
  wire sgt;
  wire eq;
  wire ult;
  wire ugt;
  assign slt = $signed(operand_a) < $signed(operand_b);
  assign sgt = $signed(operand_a) > $signed(operand_b);
  assign eq = operand_a == operand_b;
  assign ult = operand_a < operand_b;
  assign ugt = operand_a > operand_b;

  // any enabled condition fires, so an all-ones mask always traps
  assign trap_hit = (trap_condition_mask[`CRLT_TM_SLT] & slt)  // RULE_11 RULE_10 RULE_18
                  | (trap_condition_mask[`CRLT_TM_SGT] & sgt)  // RULE_12
                  | (trap_condition_mask[`CRLT_TM_EQ] & eq)    // RULE_13
                  | (trap_condition_mask[`CRLT_TM_ULT] & ult)  // RULE_14
                  | (trap_condition_mask[`CRLT_TM_UGT] & ugt); // RULE_15
endmodule // crlt_trap_cmp

// ### test/crlt_unit_assertions.sv
// port checks for crlt_unit
// assumes bind onto crlt_unit, sync active-low reset
`timescale 1ns/10ps
module crlt_chk (
  input logic clock,
  input logic resetn,
  input logic op_valid,
  input logic [2:0] op_cmd,
  input logic [4:0] trap_condition_mask,
  input logic [31:0] source_gpr_a,
  input logic [31:0] source_gpr_b,
  input logic trap_debug_enable,
  input logic cr_load,
  input logic [31:0] condition_register,
  input logic svc_exception,
  input logic prog_exception,
  input logic debug_exception,
  input logic [15:0] exception_vector,
  input logic op_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire trap_r = op_valid && op_cmd == 3'h3;
  a_done_pulse: assert property (op_valid |=> op_done) else $error("no op_done");
  a_svc_raise: assert property (op_valid && op_cmd == 3'h2 |=> svc_exception && exception_vector == 16'h0c00)
    else $error("svc missing");
  a_prog_vec: assert property (prog_exception |-> exception_vector == 16'h0700) else $error("bad vector");
  a_dbg_pair: assert property (prog_exception |-> debug_exception == $past(trap_debug_enable))
    else $error("debug mismatch");
  a_all_mask: assert property (trap_r && trap_condition_mask == 5'h1f |=> prog_exception) else $error("no trap");
  a_eq_trap: assert property (trap_r && trap_condition_mask[2] && source_gpr_a == source_gpr_b |=> prog_exception)
    else $error("eq trap missing");
  a_no_mask: assert property (trap_r && trap_condition_mask == 5'h00 |=> !prog_exception) else $error("spurious");
  a_cr_hold: assert property (!op_valid && !cr_load |=> $stable(condition_register)) else $error("cr moved");
  cover property (svc_exception);
  cover property (prog_exception && debug_exception);
  cover property (trap_r && trap_condition_mask == 5'h1f);
endmodule // crlt_chk
bind crlt_unit crlt_chk u_chk (.*);

// ### test/crlt_seq_model.sv
// exception sequencing side: latches the vector of each taken exception
// assumes one-cycle exception pulses
`timescale 1ns/10ps
module crlt_seq_model (
  input logic clock,
  input logic svc_exception,
  input logic prog_exception,
  input logic [15:0] exception_vector,
  output logic [15:0] taken_vec
);
  initial taken_vec = 16'h0000;
  // a pulse is seen at one edge only; a late sample loses it
  always @(posedge clock) begin
    if (svc_exception || prog_exception) taken_vec <= exception_vector;
  end
endmodule // crlt_seq_model

// ### test/crlt_unit_tb.sv
// self-checking bench for crlt_unit
// assumes checker and sequencing model compiled alongside
`timescale 1ns/10ps
module crlt_unit_tb;
  logic clock = 0, resetn = 0, op_valid = 0, user_mode = 0, trap_debug_enable = 0, cr_load = 0;
  logic [2:0] op_cmd = 0, bit_op = 0, source_field = 0, dest_field = 0;
  logic [4:0] source_bit_a = 0, source_bit_b = 0, dest_bit = 0, trap_condition_mask = 0;
  logic [31:0] source_gpr_a = 0, source_gpr_b = 0, cr_load_data = 0, condition_register, exp_cr;
  logic [15:0] signed_immediate = 0, exception_vector, taken_vec;
  logic svc_exception, prog_exception, debug_exception, enter_privileged, op_done, a, b, r;
  int errors = 0, total_checks = 0, cycles = 0;
  // truth tables indexed by {a,b}, one per bit op code
  logic [3:0] tt [8] = '{4'h8, 4'h4, 4'h9, 4'h7, 4'h1, 4'he, 4'hd, 4'h6};
  logic [70:0] rows [13] = '{
    {1'b0, 5'h10, 32'hffffffff, 32'h1, 1'b1}, {1'b0, 5'h10, 32'h1, 32'hffffffff, 1'b0},
    {1'b0, 5'h08, 32'h1, 32'hffffffff, 1'b1}, {1'b0, 5'h08, 32'hffffffff, 32'h1, 1'b0},
    {1'b0, 5'h02, 32'h1, 32'hffffffff, 1'b1}, {1'b0, 5'h01, 32'h1, 32'hffffffff, 1'b0},
    {1'b0, 5'h01, 32'hffffffff, 32'h1, 1'b1}, {1'b0, 5'h1b, 32'h5, 32'h5, 1'b0},
    {1'b0, 5'h1f, 32'h3, 32'h9, 1'b1}, {1'b1, 5'h04, 32'hfffffffe, 32'hfffe, 1'b1},
    {1'b1, 5'h02, 32'h1, 32'h8000, 1'b1}, {1'b0, 5'h00, 32'h5, 32'h5, 1'b0},
    {1'b0, 5'h04, 32'h7, 32'h7, 1'b1}};
  crlt_unit dut (.*);
  crlt_seq_model model (.*);
  initial forever #5 clock = ~clock;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task issue(input logic [2:0] cmd);
    @(posedge clock);
    op_cmd <= cmd;
    op_valid <= 1'b1;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      finish_test;
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    #1 check(condition_register, 32'h0);
    cr_load_data <= 32'h5a3c96e1;
    cr_load <= 1'b1;
    issue(3'h0);
    cr_load <= 1'b0;
    exp_cr = 32'h5a3c96e1;
    check(condition_register, exp_cr);
    for (int k = 0; k < 32; k++) begin
      source_bit_a <= k[4:0];
      source_bit_b <= 5'(31 - k);
      dest_bit <= 5'(k * 7);
      bit_op <= k[2:0];
      a = exp_cr[31 - k];
      b = exp_cr[k];
      r = tt[k % 8][{a, b}];
      exp_cr[31 - ((k * 7) % 32)] = r;
      issue(3'h0);
      check(condition_register, exp_cr);
    end
    source_field <= 3'h7;
    exp_cr[31:28] = exp_cr[3:0];
    issue(3'h1);
    check(condition_register, exp_cr);
    user_mode <= 1'b1;
    issue(3'h2);
    check({op_done, svc_exception, enter_privileged, exception_vector}, {3'b111, 16'h0c00});
    for (int i = 0; i < 13; i++) begin
      {trap_condition_mask, source_gpr_a, source_gpr_b} <= rows[i][69:1];
      signed_immediate <= rows[i][16:1];
      trap_debug_enable <= i[0];
      issue(rows[i][70] ? 3'h4 : 3'h3);
      check({prog_exception, debug_exception, exception_vector}, {rows[i][0], rows[i][0] & i[0],
        rows[i][0] ? 16'h0700 : 16'h0000});
    end
    check(taken_vec, 16'h0700);
    // unknown command: no exception, no register change, vector cleared
    issue(3'h5);
    check({op_done, svc_exception, prog_exception, exception_vector}, {3'b100, 16'h0000});
    check(condition_register, exp_cr);
    // service call from supervisor mode: exception but no mode entry
    user_mode <= 1'b0;
    issue(3'h2);
    check({svc_exception, enter_privileged, exception_vector}, {2'b10, 16'h0c00});
    resetn <= 1'b0;
    @(posedge clock);
    #1 check(condition_register, 32'h0);
    check({svc_exception, prog_exception, debug_exception, enter_privileged, exception_vector}, 32'h0);
    finish_test;
  end
endmodule // crlt_unit_tb
